// ### src/tcwd_pkg.sv
// Purpose: shared constants and types for the tuner control word decoder
// Assumes: words arrive lsb first on the three-wire bus, address in top two bits
// Notes:   bit positions are those of the serial word as shifted in
package tcwd_pkg;

  // ----------------------------------------
  // word lengths and addresses
  // ----------------------------------------
  localparam int unsigned SHORT_LEN = 8;
  localparam int unsigned LONG_LEN  = 16;
  localparam int unsigned CNT_W     = 5;
  localparam logic [1:0]  ADR_PLL   = 2'h0;
  localparam logic [1:0]  ADR_IFG   = 2'h1;
  localparam logic [1:0]  ADR_BAND  = 2'h2;
  localparam logic [1:0]  ADR_PUMP  = 2'h3;
  localparam logic [1:0]  ADR_DOFS  = 2'h0;
  localparam logic [1:0]  ADR_DGAIN = 2'h1;

  // ----------------------------------------
  // field positions inside a received word
  // ----------------------------------------
  localparam int unsigned POS_IF_LOOP_THR = 0;
  localparam int unsigned POS_PDTEST      = 3;
  localparam int unsigned POS_PLL_ON      = 4;
  localparam int unsigned POS_DIVSEL      = 5;
  localparam int unsigned POS_IFGAIN      = 0;
  localparam int unsigned POS_OSC         = 4;
  localparam int unsigned POS_IFIN        = 5;
  localparam int unsigned POS_RF_LOOP_THR = 0;
  localparam int unsigned POS_IF_LOOP_OFF = 4;
  localparam int unsigned POS_AM          = 5;
  localparam int unsigned POS_DLYSEL      = 0;
  localparam int unsigned POS_DLY1        = 2;
  localparam int unsigned POS_DLY2        = 4;
  localparam int unsigned POS_SHIFT_OFF   = 8;
  localparam int unsigned POS_DOFS        = 0;
  localparam int unsigned POS_DGAIN       = 0;
  localparam int unsigned POS_SWITCH_ONE  = 8;
  localparam int unsigned POS_SWITCH_TWO  = 9;
  localparam int unsigned POS_SWITCH_MODE = 10;

  // ----------------------------------------
  // decode constants
  // ----------------------------------------
  localparam logic [7:0] IFGAIN_BASE_DB = 8'h0c;
  localparam logic [7:0] RF_AM_BASE_DB  = 8'h58;
  localparam logic [7:0] RF_FM_BASE_DB  = 8'h5b;
  localparam logic [7:0] DELAY_STEP_NS  = 8'h05;
  localparam logic [7:0] IF_THR_CODE0   = 8'h6d;
  localparam logic [7:0] IF_THR_CODE1   = 8'h6f;
  localparam logic [7:0] IF_THR_CODE2   = 8'h71;
  localparam logic [7:0] IF_THR_CODE3   = 8'h73;
  localparam logic [7:0] IF_THR_CODE4   = 8'h75;
  localparam logic [7:0] IF_THR_CODE5   = 8'h76;
  localparam logic [7:0] IF_THR_CODE6   = 8'h77;
  localparam logic [7:0] IF_THR_CODE7   = 8'h79;

  typedef struct packed {
    logic [7:0] pll_control_word;
    logic [7:0] if_gain_oscillator_word;
    logic [7:0] band_agc_word;
    logic [7:0] charge_pump_delay_word;
    logic [15:0] alignment_converter_one_offset_shift_word;
    logic [15:0] alignment_converter_one_gain_switch_word;
  } tcwd_words_t;

  typedef struct packed {
    logic [7:0] if_gain_loop_thr_dbuv;
    logic       if_gain_loop_on;
    logic       phase_detector_test;
    logic       pll_on;
    logic       divider_choice;
    logic [7:0] if_gain_db;
    logic       if_input_am;
    logic       oscillator_current_select;
    logic [7:0] rf_gain_loop_thr_db;
    logic       am_mode;
    logic       pump_delay_select;
    logic       high_pump_on;
    logic [7:0] high_pump_delay_ns;
    logic       divider_shift;
    logic [6:0] alignment_converter_one_offset;
    logic [7:0] alignment_converter_one_gain;
    logic       switch_output_one_low;
    logic       switch_two_or_gain_pin_sw;
    logic       switch_two_low;
  } tcwd_settings_t;

endpackage

// ### src/tcwd_serial_rx.sv
// Purpose: shift register on the three-wire bus clock
// Assumes: enable high frames a word, data sampled on rising bus clock
// Notes:   word and length held stable once the bus clock stops
`timescale 1ns/1ps
module tcwd_serial_rx (
  input  wire logic                         i_bus_clock,
  input  wire logic                         i_arst_n,
  input  wire logic                         i_enable,
  input  wire logic                         i_data,
  output logic [tcwd_pkg::LONG_LEN-1:0]     o_word,
  output logic [tcwd_pkg::CNT_W-1:0]        o_count
);
  import tcwd_pkg::*;

  // ----------------------------------------
  // shift while framed, lsb first
  // ----------------------------------------
  always_ff @(posedge i_bus_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_word <= '0;
    end else if (i_enable) begin
      o_word <= {i_data, o_word[LONG_LEN-1:1]};
    end
  end

  // ----------------------------------------
  // bit count, restarts with each frame
  // ----------------------------------------
  logic framed;
  always_ff @(posedge i_bus_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      framed <= 1'b0;
    end else begin
      framed <= i_enable;
    end
  end

  always_ff @(posedge i_bus_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_count <= '0;
    end else if (i_enable && !framed) begin
      o_count <= CNT_W'(1);
    end else if (i_enable && o_count != '1) begin
      o_count <= o_count + CNT_W'(1);
    end
  end
endmodule

// ### src/tcwd_top.sv
// Purpose: hold and decode tuner control words from the three-wire bus
// Assumes: bus clock runs two cycles past each frame, then stops; i_clock free running at 10 MHz
// Notes:   enable is the frame marker and is synchronised into i_clock
`timescale 1ns/1ps

// Function
// R1 - if gain threshold 109..121 dBuV table
// R2 - bit 16 low keeps if loop on
// R3 - bit 3 routes phase detector test
// R4 - bit 5 picks second divider
// R5 - if gain 12 dB plus 2 dB steps
// R6 - bit 11 selects am if input
// R7 - bit 10 selects low oscillator current
// R8 - rf threshold 1 dB steps from base
// R9 - bit 17 picks am or fm table
// R10 - bit 17 sets am reception mode
// R11 - host writes zero to required bits
// R12 - pump word holds two delays, select
// R13 - select bit picks active delay field
// R14 - delay 00 off, else 5 ns steps
// R15 - bit 32 low enables divider shift
// R16 - frame ends, word latched by address
// R17 - ignore dont care, others unchanged
module tcwd_top (
  input  wire logic                     i_clock,
  input  wire logic                     i_arst_n,
  input  wire logic                     i_bus_clock,
  input  wire logic                     i_bus_enable,
  input  wire logic                     i_bus_data,
  output tcwd_pkg::tcwd_words_t         o_words,
  output tcwd_pkg::tcwd_settings_t      o_settings,
  output logic                          o_am_loop_filter_output_test
);
  import tcwd_pkg::*;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (LONG_LEN < SHORT_LEN) begin : g_bad_len
    $error("short word longer than long word");
  end
  if ((1 << CNT_W) <= LONG_LEN) begin : g_bad_cnt
    $error("bit counter too narrow for long word");
  end

  // ----------------------------------------
  // link domain receiver
  // ----------------------------------------
  logic [LONG_LEN-1:0] rx_word;
  logic [CNT_W-1:0]    rx_count;
  logic                bus_data_meta;
  logic                bus_data_sync;
  logic                en_link_meta;
  logic                en_link_sync;

  always_ff @(posedge i_bus_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_data_meta <= 1'b0;
      bus_data_sync <= 1'b0;
      en_link_meta  <= 1'b0;
      en_link_sync  <= 1'b0;
    end else begin
      bus_data_meta <= i_bus_data;
      bus_data_sync <= bus_data_meta;
      en_link_meta  <= i_bus_enable;
      en_link_sync  <= en_link_meta;
    end
  end

  tcwd_serial_rx u_rx (
    .i_bus_clock (i_bus_clock),
    .i_arst_n    (i_arst_n),
    .i_enable    (en_link_sync),
    .i_data      (bus_data_sync),
    .o_word      (rx_word),
    .o_count     (rx_count)
  );

  // ----------------------------------------
  // frame end detect in system domain
  // ----------------------------------------
  logic en_meta;
  logic en_sync;
  logic en_last;
  logic frame_end;
  logic frame_end_d;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      en_meta <= 1'b0;
      en_sync <= 1'b0;
      en_last <= 1'b0;
    end else begin
      en_meta <= i_bus_enable;
      en_sync <= en_meta;
      en_last <= en_sync;
    end
  end

  assign frame_end = en_last && !en_sync;

  // word is stable once the bus clock stops; wait one more cycle
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      frame_end_d <= 1'b0;
    end else begin
      frame_end_d <= frame_end;
    end
  end

  logic                stage_take;
  logic [LONG_LEN-1:0] stage_word;
  logic [CNT_W-1:0]    stage_count;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stage_take  <= 1'b0;
      stage_word  <= '0;
      stage_count <= '0;
    end else begin
      stage_take  <= frame_end_d;
      if (frame_end_d) begin
        stage_word  <= rx_word;
        stage_count <= rx_count;
      end
    end
  end

  // ----------------------------------------
  // word store
  // ----------------------------------------
  logic                 is_short;
  logic                 is_long;
  logic [SHORT_LEN-1:0] short_word;
  logic [1:0]           short_adr;
  logic [1:0]           long_adr;

  assign is_short   = stage_count == CNT_W'(SHORT_LEN);
  assign is_long    = stage_count == CNT_W'(LONG_LEN);
  assign short_word = stage_word[LONG_LEN-1 -: SHORT_LEN];
  assign short_adr  = short_word[SHORT_LEN-1 -: 2];
  assign long_adr   = stage_word[LONG_LEN-1 -: 2];

  // R16 latch at frame end
  // R17 one word per frame
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_words <= '0;
    end else if (stage_take && is_short) begin
      unique case (short_adr)
        ADR_PLL:  o_words.pll_control_word        <= short_word;
        ADR_IFG:  o_words.if_gain_oscillator_word <= short_word;
        ADR_BAND: o_words.band_agc_word           <= short_word;
        ADR_PUMP: o_words.charge_pump_delay_word  <= short_word;
      endcase
    end else if (stage_take && is_long) begin
      if (long_adr == ADR_DOFS) begin
        o_words.alignment_converter_one_offset_shift_word <= stage_word;
      end else if (long_adr == ADR_DGAIN) begin
        o_words.alignment_converter_one_gain_switch_word <= stage_word;
      end
    end
  end

  // ----------------------------------------
  // decode functions
  // ----------------------------------------
  function automatic logic [7:0] if_thr(input logic [2:0] code);
    logic [7:0] v;
    // R1 threshold table
    unique case (code)
      3'h0: v = IF_THR_CODE0;
      3'h1: v = IF_THR_CODE1;
      3'h2: v = IF_THR_CODE2;
      3'h3: v = IF_THR_CODE3;
      3'h4: v = IF_THR_CODE4;
      3'h5: v = IF_THR_CODE5;
      3'h6: v = IF_THR_CODE6;
      3'h7: v = IF_THR_CODE7;
    endcase
    return v;
  endfunction

  function automatic logic [7:0] pump_delay(input logic [1:0] code);
    // R14 5 ns steps
    return 8'(code * DELAY_STEP_NS);
  endfunction

  // ----------------------------------------
  // decoded settings
  // ----------------------------------------
  tcwd_words_t    w;
  tcwd_settings_t next_settings;
  logic [1:0]     dly;
  assign w = o_words;

  always_comb begin
    next_settings = '0;
    next_settings.if_gain_loop_thr_dbuv = if_thr(w.pll_control_word[POS_IF_LOOP_THR +: 3]);
    // R3 test routing
    next_settings.phase_detector_test = w.pll_control_word[POS_PDTEST];
    next_settings.pll_on              = w.pll_control_word[POS_PLL_ON];
    // R4 divider choice
    next_settings.divider_choice      = w.pll_control_word[POS_DIVSEL];
    // R5 linear gain
    next_settings.if_gain_db = IFGAIN_BASE_DB
      + {3'h0, w.if_gain_oscillator_word[POS_IFGAIN +: 4], 1'b0};
    // R7 oscillator current
    next_settings.oscillator_current_select = w.if_gain_oscillator_word[POS_OSC];
    // R6 if input
    next_settings.if_input_am = w.if_gain_oscillator_word[POS_IFIN];
    // R2 loop enable
    next_settings.if_gain_loop_on = !w.band_agc_word[POS_IF_LOOP_OFF];
    // R10 reception mode
    next_settings.am_mode = w.band_agc_word[POS_AM];
    // R8 R9 table pick
    next_settings.rf_gain_loop_thr_db =
      (w.band_agc_word[POS_AM] ? RF_AM_BASE_DB : RF_FM_BASE_DB)
      + {4'h0, w.band_agc_word[POS_RF_LOOP_THR +: 4]};
    // R12 R13 field select
    next_settings.pump_delay_select = w.charge_pump_delay_word[POS_DLYSEL];
    dly = w.charge_pump_delay_word[POS_DLYSEL]
        ? w.charge_pump_delay_word[POS_DLY2 +: 2]
        : w.charge_pump_delay_word[POS_DLY1 +: 2];
    // R14 zero disables
    next_settings.high_pump_on       = dly != 2'h0;
    next_settings.high_pump_delay_ns = pump_delay(dly);
    // R15 shift active low
    next_settings.divider_shift = !w.alignment_converter_one_offset_shift_word[POS_SHIFT_OFF];
    next_settings.alignment_converter_one_offset = w.alignment_converter_one_offset_shift_word[POS_DOFS +: 7];
    next_settings.alignment_converter_one_gain   = w.alignment_converter_one_gain_switch_word[POS_DGAIN +: 8];
    next_settings.switch_output_one_low     = w.alignment_converter_one_gain_switch_word[POS_SWITCH_ONE];
    next_settings.switch_two_low            = w.alignment_converter_one_gain_switch_word[POS_SWITCH_TWO];
    next_settings.switch_two_or_gain_pin_sw = w.alignment_converter_one_gain_switch_word[POS_SWITCH_MODE];
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_settings <= '0;
    end else begin
      o_settings <= next_settings;
    end
  end

  // R3 pin routing
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_am_loop_filter_output_test <= 1'b0;
    end else begin
      o_am_loop_filter_output_test <= next_settings.phase_detector_test;
    end
  end
endmodule

// ### verification/tcwd_checker.sv
// Purpose: assertions on decoded tuner settings
// Assumes: settings follow stored words by one cycle
// Notes:   checks start one cycle after reset release, except one_word_a which is not gated by rdy
`timescale 1ns/1ps
module tcwd_checker (
  input  wire logic                i_clock,
  input  wire logic                i_arst_n,
  input  tcwd_pkg::tcwd_words_t    o_words,
  input  tcwd_pkg::tcwd_settings_t o_settings,
  input  wire logic                o_am_loop_filter_output_test
);
  import tcwd_pkg::*;
  localparam logic [7:0] THR [8] = '{8'h6d, 8'h6f, 8'h71, 8'h73, 8'h75, 8'h76, 8'h77, 8'h79};
  logic        rdy;
  tcwd_words_t w;
  logic [1:0]  act;
  assign act = w.charge_pump_delay_word[0] ? w.charge_pump_delay_word[5:4]
                                           : w.charge_pump_delay_word[3:2];
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdy <= 1'b0;
      w   <= '0;
    end else begin
      rdy <= 1'b1;
      w   <= o_words;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  if_thr_a: assert property (
    rdy |-> o_settings.if_gain_loop_thr_dbuv == THR[w.pll_control_word[2:0]])
    else $error("if threshold wrong");
  if_loop_a: assert property (
    rdy |-> o_settings.if_gain_loop_on == !w.band_agc_word[4]) else $error("if loop wrong");
  div_sel_a: assert property (
    rdy |-> o_settings.divider_choice == w.pll_control_word[5]) else $error("divider wrong");
  if_gain_a: assert property (
    rdy |-> o_settings.if_gain_db == 8'h0c + 2 * w.if_gain_oscillator_word[3:0])
    else $error("if gain wrong");
  if_input_osc_a: assert property (
    rdy |-> {o_settings.if_input_am, o_settings.oscillator_current_select}
            == w.if_gain_oscillator_word[5:4]) else $error("input or osc wrong");
  rf_thr_a: assert property (
    rdy |-> o_settings.am_mode == w.band_agc_word[5] && o_settings.rf_gain_loop_thr_db
      == (w.band_agc_word[5] ? 8'h58 : 8'h5b) + w.band_agc_word[3:0]) else $error("rf wrong");
  pump_dly_a: assert property (
    rdy |-> o_settings.high_pump_delay_ns == 5 * act && o_settings.high_pump_on == (act != 0))
    else $error("pump delay wrong");
  div_shift_a: assert property (
    rdy |-> o_settings.divider_shift == !w.alignment_converter_one_offset_shift_word[8]) else $error("shift wrong");
  pdt_route_a: assert property (
    rdy |-> o_am_loop_filter_output_test == w.pll_control_word[3])
    else $error("test routing wrong");
  pump_sel_a: assert property (
    rdy |-> o_settings.pump_delay_select == w.charge_pump_delay_word[0])
    else $error("pump select wrong");
  dac_fields_a: assert property (
    rdy |-> {o_settings.switch_two_or_gain_pin_sw, o_settings.switch_two_low,
             o_settings.switch_output_one_low, o_settings.alignment_converter_one_gain}
            == w.alignment_converter_one_gain_switch_word[10:0]) else $error("gain word fields wrong");
  one_word_a: assert property (
    $onehot0({$changed(o_words.pll_control_word), $changed(o_words.if_gain_oscillator_word),
      $changed(o_words.band_agc_word), $changed(o_words.charge_pump_delay_word),
      $changed(o_words.alignment_converter_one_offset_shift_word), $changed(o_words.alignment_converter_one_gain_switch_word)}))
    else $error("several words changed");
endmodule

// ### verification/tcwd_host_model.sv
// Purpose: host driving the three-wire bus
// Assumes: bus clock 125 ns, stopped between frames
// Notes:   data inverted when not carrying a word bit
`timescale 1ns/1ps
module tcwd_host_model (
  output logic o_bus_clock,
  output logic o_bus_enable,
  output logic o_bus_data
);
  initial begin
    o_bus_clock  = 1'b0;
    o_bus_enable = 1'b0;
    o_bus_data   = 1'b0;
  end
  task automatic send(input logic [15:0] w, input int n);
    #37;
    for (int k = 0; k < n + 2; k++) begin
      o_bus_enable = (k < n);
      o_bus_data   = (k < n) ? w[k] : ~o_bus_data;
      #62.5 o_bus_clock = 1'b1;
      #62.5 o_bus_clock = 1'b0;
    end
    o_bus_data = ~o_bus_data;
  endtask
endmodule

// ### verification/tuner_control_word_decoder_test.sv
// Purpose: self-checking bench for the control word decoder
// Assumes: answer within 10 cycles of frame end
// Notes:   host model drives the bus
`timescale 1ns/1ps
module tuner_control_word_decoder_test;
  import tcwd_pkg::*;
  localparam logic [7:0] THR [8] = '{8'h6d, 8'h6f, 8'h71, 8'h73, 8'h75, 8'h76, 8'h77, 8'h79};
  logic           i_clock;
  logic           i_arst_n;
  logic           bus_clock;
  logic           bus_enable;
  logic           bus_data;
  tcwd_words_t    o_words;
  tcwd_settings_t o_settings;
  logic           o_pdt;
  tcwd_words_t    saved;
  int             miscompares = 0;
  int             tests_run = 0;
  int             cycles = 0;
  tcwd_host_model host (.o_bus_clock(bus_clock), .o_bus_enable(bus_enable), .o_bus_data(bus_data));
  tcwd_top DUT (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_bus_clock(bus_clock),
    .i_bus_enable(bus_enable), .i_bus_data(bus_data), .o_words(o_words),
    .o_settings(o_settings), .o_am_loop_filter_output_test(o_pdt));
  always #50 i_clock = ~i_clock;
  task automatic end_sim();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] w, input int n);
    host.send(w, n);
    repeat (10) @(negedge i_clock);
  endtask
  task automatic t_pll();
    for (int k = 0; k < 8; k++) begin
      wr({ADR_PLL, k[0], k[1], k[2], 3'(k)}, 8);
      chk("thr", o_settings.if_gain_loop_thr_dbuv, THR[k]);
      chk("div", o_settings.divider_choice, k[0]);
      chk("pdt", o_pdt, k[2]);
      chk("pllon", o_settings.pll_on, k[1]);
    end
    wr({ADR_PLL, 6'h10}, 8);
    chk("pdt", o_pdt, 1'b0);
    chk("pllon", o_settings.pll_on, 1'b1);
    $display("done pll");
  endtask
  task automatic t_ifg_band();
    for (int k = 0; k < 4; k++) begin
      wr({ADR_IFG, k[1], k[0], 4'(k * 5)}, 8);
      chk("gain", o_settings.if_gain_db, 12 + 2 * k * 5);
      chk("ifin", o_settings.if_input_am, k[1]);
      chk("osc", o_settings.oscillator_current_select, k[0]);
      wr({ADR_BAND, k[0], k[1], 4'(k * 5)}, 8);
      chk("rf", o_settings.rf_gain_loop_thr_db, (k[0] ? 88 : 91) + k * 5);
      chk("am", o_settings.am_mode, k[0]);
      chk("loop", o_settings.if_gain_loop_on, !k[1]);
      chk("pllw", o_words.pll_control_word[5:0], 6'h10);
    end
    $display("done ifg band");
  endtask
  task automatic t_pump();
    logic [1:0] a;
    for (int k = 0; k < 8; k++) begin
      a = k[0] ? ~k[2:1] : k[2:1];
      wr({ADR_PUMP, ~k[2:1], k[2:1], 1'b0, k[0]}, 8);
      chk("pumpw", o_words.charge_pump_delay_word[5:0], {~k[2:1], k[2:1], 1'b0, k[0]});
      chk("sel", o_settings.pump_delay_select, k[0]);
      chk("dly", o_settings.high_pump_delay_ns, 5 * a);
      chk("on", o_settings.high_pump_on, a != 0);
    end
    $display("done pump");
  endtask
  task automatic t_long();
    for (int k = 0; k < 2; k++) begin
      wr({ADR_DOFS, 4'h0, 1'b0, k[0], 1'b0, 7'(7'h2a + k)}, 16);
      chk("shift", o_settings.divider_shift, !k[0]);
      chk("ofs", o_settings.alignment_converter_one_offset, 7'h2a + k);
      wr({ADR_DGAIN, 3'h0, k[0], 1'b1, ~k[0], 8'(8'h81 + k)}, 16);
      chk("dgain", o_settings.alignment_converter_one_gain, 8'h81 + k);
      chk("swone", o_settings.switch_output_one_low, !k[0]);
      chk("swtwo", o_settings.switch_two_low, 1'b1);
      chk("swmode", o_settings.switch_two_or_gain_pin_sw, k[0]);
    end
    saved = o_words;
    wr({2'h2, 14'h3fff}, 16);
    wr(16'h0fff, 12);
    chk("refused", o_words, saved);
    $display("done long");
  endtask
  task automatic t_reset();
    i_arst_n = 1'b0;
    fork
      host.send('0, 2);
      repeat (12) @(posedge i_clock);
    join
    @(negedge i_clock);
    i_arst_n = 1'b1;
    wr('0, 2);
    chk("rst", o_words, '0);
    chk("rthr", o_settings.if_gain_loop_thr_dbuv, THR[0]);
    chk("rgain", o_settings.if_gain_db, 12);
    chk("rrf", o_settings.rf_gain_loop_thr_db, 91);
    chk("rloop", o_settings.if_gain_loop_on, 1'b1);
    chk("rshift", o_settings.divider_shift, 1'b1);
    $display("done reset");
  endtask
  initial begin
    i_clock = 1'b0;
    t_reset();
    t_pll();
    t_ifg_band();
    t_pump();
    t_long();
    end_sim();
  end
endmodule
bind tcwd_top tcwd_checker u_chk (.i_clock(i_clock), .i_arst_n(i_arst_n),
  .o_words(o_words), .o_settings(o_settings),
  .o_am_loop_filter_output_test(o_am_loop_filter_output_test));
